// *** pkg/rcr_pkg.sv ***
// constants and types of the reset cause recorder
package rcr_pkg;
    // clock rate and timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    localparam int unsigned T_POR_US = 10;
    localparam int unsigned POR_CYCLES = T_POR_US * CLK_MHZ;
    localparam int unsigned T_POWER_UP_DELAY_TIMER_A_MS = 4;
    localparam int unsigned T_POWER_UP_DELAY_TIMER_B_MS = 16;
    localparam int unsigned T_POWER_UP_DELAY_TIMER_C_MS = 64;
    localparam int unsigned POWER_UP_DELAY_TIMER_A_CYCLES = T_POWER_UP_DELAY_TIMER_A_MS * CYC_PER_MS;
    localparam int unsigned POWER_UP_DELAY_TIMER_B_CYCLES = T_POWER_UP_DELAY_TIMER_B_MS * CYC_PER_MS;
    localparam int unsigned POWER_UP_DELAY_TIMER_C_CYCLES = T_POWER_UP_DELAY_TIMER_C_MS * CYC_PER_MS;
    localparam int unsigned DLY_W = 24;
    // watchdog rc tick and time-out
    localparam int unsigned WDT_TICK_DIV = 100;
    localparam int unsigned WDT_TIMEOUT_TICKS = 2048;
    localparam int unsigned WDT_W = 16;
    // power-up delay selections
    localparam logic [1:0] POWER_UP_DELAY_TIMER_SEL_NONE = 2'h0;
    localparam logic [1:0] POWER_UP_DELAY_TIMER_SEL_A = 2'h1;
    localparam logic [1:0] POWER_UP_DELAY_TIMER_SEL_B = 2'h2;
    // program counter
    localparam int unsigned PC_W = 24;
    localparam logic [PC_W-1:0] VEC_RESET = 24'h000000;
    localparam logic [PC_W-1:0] VEC_CLKFAIL = 24'h000004;
    localparam logic [PC_W-1:0] PC_STEP = 24'h000002;
    // register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OSC = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_WDT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 4'h4;
    // reset cause flag positions
    localparam int unsigned FLG_W = 8;
    localparam int unsigned FLG_POWERUP = 0;
    localparam int unsigned FLG_DEEPSTOP = 1;
    localparam int unsigned FLG_DOZE = 2;
    localparam int unsigned FLG_WDT = 3;
    localparam int unsigned FLG_SW = 4;
    localparam int unsigned FLG_EXT = 5;
    localparam int unsigned FLG_ILL = 6;
    localparam int unsigned FLG_TRAP = 7;
    localparam logic [FLG_W-1:0] CAUSE_RESET = 8'h01;
    // oscillator control fields and watchdog kick bit
    localparam int unsigned OSC_SWREQ = 0;
    localparam int unsigned OSC_FAIL = 3;
    localparam int unsigned OSC_CUR_LSB = 4;
    localparam int unsigned OSC_CUR_W = 3;
    localparam logic [OSC_CUR_W-1:0] OSC_SEL_FAST = 3'h1;
    localparam int unsigned WDT_KICK = 0;
    // interrupt status positions
    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_CLKFAIL = 0;
    localparam int unsigned INT_WDT = 1;
    localparam int unsigned INT_EVENT = 2;

    typedef struct packed {
        logic swReset;
        logic trapLockup;
        logic illegalOp;
        logic irqWake;
        logic sleepMode;
        logic idleMode;
    } rcr_core_evt_t;

    typedef struct packed {
        logic masterClearN;
        logic oscRunning;
        logic startupDone;
        logic pllLocked;
        logic clockFail;
    } rcr_pins_t;

    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_IDLE} rcr_mode_t;
endpackage

// *** rtl/rcr_rc_tick.sv ***
// divider that stands in for the watchdog rc oscillator
`timescale 1ns/1ps
`default_nettype none
module rcr_rc_tick #(
    parameter int unsigned DIV = rcr_pkg::WDT_TICK_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // tick
    output logic tick
);
    logic [15:0] cnt_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // rcr_rc_tick
`default_nettype wire

// *** rtl/rcr_watchdog.sv ***
// free-running watchdog counter on the rc tick
`timescale 1ns/1ps
`default_nettype none
module rcr_watchdog #(
    parameter int unsigned TIMEOUT_TICKS = rcr_pkg::WDT_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic enable,
    input wire logic kick,
    // time-out
    output logic timeout
);
    logic tick;
    logic [rcr_pkg::WDT_W-1:0] cnt_q;

    rcr_rc_tick #(.DIV(rcr_pkg::WDT_TICK_DIV)) uTick (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    // counts on its own tick, blind to main clock failure [RULE_14]
    always_ff @(posedge clock) begin
        if (sys_rst || kick || !enable) begin
            cnt_q <= '0;
            timeout <= 1'b0;
        end else if (tick && cnt_q == rcr_pkg::WDT_W'(TIMEOUT_TICKS - 1)) begin
            cnt_q <= '0;
            timeout <= 1'b1;
        end else begin
            cnt_q <= tick ? cnt_q + 1'b1 : cnt_q;
            timeout <= 1'b0;
        end
    end
endmodule // rcr_watchdog
`default_nettype wire

// *** rtl/rcr_top.sv ***
// reset cause recorder: power-up exit, cause flags, pc load
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - power-up delay expiry is independent of oscillator start-up
// RULE_02 - monitor on and clock not ready: trap, vector 4, fast oscillator, flags kept
// RULE_03 - monitor and delay timer both off: leave reset promptly
// RULE_04 - monitor off and no clock: hold core frozen at reset vector
// RULE_05 - cause flags readable and writable; untouched flags keep value
// RULE_06 - power-on: pc zero, power-up flag set, others cleared
// RULE_07 - pin reset running: set external, clear sw/wdt/doze/deep-stop
// RULE_08 - software reset: set software, clear external/wdt/doze/deep-stop
// RULE_09 - pin reset in sleep: set external and deep-stop, clear wdt/doze
// RULE_10 - pin reset in idle: set external and doze, clear wdt/deep-stop
// RULE_11 - watchdog reset to zero; watchdog wake continues at pc plus two
// RULE_12 - interrupt wake from sleep: set deep-stop, load interrupt vector
// RULE_13 - trap lock-up and illegal operation reset to zero, set own flag
// RULE_14 - watchdog runs free on its own rc tick
// RULE_15 - wait bias delay plus selected power-up delay, then release
// RULE_16 - clock failure: fast oscillator field, fail flag set, switch request cleared
// RULE_17 - watchdog time-out resets, except in sleep where it wakes
// RULE_18 - flag update and pc load happen in the release cycle
module rcr_top #(
    parameter int unsigned POWER_UP_DELAY_TIMER_A_CYCLES = rcr_pkg::POWER_UP_DELAY_TIMER_A_CYCLES,
    parameter int unsigned POWER_UP_DELAY_TIMER_B_CYCLES = rcr_pkg::POWER_UP_DELAY_TIMER_B_CYCLES,
    parameter int unsigned POWER_UP_DELAY_TIMER_C_CYCLES = rcr_pkg::POWER_UP_DELAY_TIMER_C_CYCLES,
    parameter int unsigned WDT_TIMEOUT_TICKS = rcr_pkg::WDT_TIMEOUT_TICKS
) (
    // clock and power-on reset
    input wire logic clock,
    input wire logic sys_rst,
    // configuration straps
    input wire logic fscmEnable,
    input wire logic [1:0] pwrtSel,
    input wire logic wdtEnable,
    input wire logic [rcr_pkg::OSC_CUR_W-1:0] oscCfgSel,
    // pins and clock status
    input wire rcr_pkg::rcr_pins_t pins,
    // core events
    input wire rcr_pkg::rcr_core_evt_t coreEvt,
    input wire logic [rcr_pkg::PC_W-1:0] curPc,
    input wire logic [rcr_pkg::PC_W-1:0] irqVector,
    // register port
    input wire logic [rcr_pkg::ADDR_W-1:0] addr,
    input wire logic [rcr_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [rcr_pkg::DATA_W-1:0] rdData,
    // core control
    output logic systemReset,
    output logic coreFrozen,
    output logic pcLoad,
    output logic [rcr_pkg::PC_W-1:0] pcValue,
    output logic clockFailTrap,
    output logic [rcr_pkg::OSC_CUR_W-1:0] currentOscField,
    output logic irq
);
    typedef enum logic [2:0] {ST_CAPTURE, ST_DELAY, ST_FREEZE, ST_RUN, ST_PIN_HOLD} rcr_state_t;
    typedef enum logic [3:0] {
        EV_NONE, EV_POR, EV_CLKTRAP, EV_PIN, EV_SW, EV_WDT_RST, EV_WDT_WAKE,
        EV_IRQ, EV_TRAP, EV_ILL
    } rcr_evt_t;

    rcr_state_t state_q, state_d;
    rcr_evt_t evt;
    rcr_pkg::rcr_mode_t pinMode_q;
    rcr_pkg::rcr_pins_t syncA_q, syncB_q;
    logic clock_fail_monitor_q;
    logic [1:0] pwrtSel_q;
    logic [rcr_pkg::DLY_W-1:0] dlyCnt_q, dlyTarget;
    logic [rcr_pkg::FLG_W-1:0] cause_q, cause_d, flgSet, flgClr;
    logic [rcr_pkg::OSC_CUR_W-1:0] oscCur_q;
    logic oscFail_q, oscSwReq_q;
    logic [rcr_pkg::INT_W-1:0] intStat_q, intMask_q, intSet;
    logic [rcr_pkg::PC_W-1:0] evtPc;
    logic clkOk, pinLow, wdtTimeout, wdtKick;

    function automatic logic hit(input logic [rcr_pkg::ADDR_W-1:0] a,
                                 input logic [rcr_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    function automatic logic [rcr_pkg::DLY_W-1:0] pwrtCycles(input logic [1:0] sel);
        case (sel)
            rcr_pkg::POWER_UP_DELAY_TIMER_SEL_NONE: pwrtCycles = '0;
            rcr_pkg::POWER_UP_DELAY_TIMER_SEL_A: pwrtCycles = rcr_pkg::DLY_W'(POWER_UP_DELAY_TIMER_A_CYCLES);
            rcr_pkg::POWER_UP_DELAY_TIMER_SEL_B: pwrtCycles = rcr_pkg::DLY_W'(POWER_UP_DELAY_TIMER_B_CYCLES);
            default: pwrtCycles = rcr_pkg::DLY_W'(POWER_UP_DELAY_TIMER_C_CYCLES);
        endcase
    endfunction

    // two-stage synchroniser for pins and clock status
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncA_q <= '{masterClearN: 1'b1, default: 1'b0};
            syncB_q <= '{masterClearN: 1'b1, default: 1'b0};
        end else begin
            syncA_q <= pins;
            syncB_q <= syncA_q;
        end
    end

    // clock readiness is sampled, never waited on, at delay expiry [RULE_01]
    assign clkOk = syncB_q.oscRunning && syncB_q.startupDone && syncB_q.pllLocked;
    assign pinLow = !syncB_q.masterClearN;
    assign wdtKick = wrEn && hit(addr, rcr_pkg::ADDR_WDT) && wrData[rcr_pkg::WDT_KICK];

    rcr_watchdog #(.TIMEOUT_TICKS(WDT_TIMEOUT_TICKS)) uWdt (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(wdtEnable),
        .kick(wdtKick),
        .timeout(wdtTimeout)
    );

    // monitor and delay straps caught once after reset release
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clock_fail_monitor_q <= 1'b0;
            pwrtSel_q <= rcr_pkg::POWER_UP_DELAY_TIMER_SEL_NONE;
        end else if (state_q == ST_CAPTURE) begin
            clock_fail_monitor_q <= fscmEnable;
            pwrtSel_q <= pwrtSel;
        end
    end

    // bias settle plus power-up delay; no delay selected gives a prompt exit [RULE_15] [RULE_03]
    assign dlyTarget = rcr_pkg::DLY_W'(rcr_pkg::POR_CYCLES) + pwrtCycles(pwrtSel_q);

    always_ff @(posedge clock) begin
        if (sys_rst || state_q != ST_DELAY) begin
            dlyCnt_q <= '0;
        end else begin
            dlyCnt_q <= dlyCnt_q + 1'b1;
        end
    end

    // event decode and sequence
    always_comb begin
        state_d = state_q;
        evt = EV_NONE;
        case (state_q)
            ST_CAPTURE: state_d = ST_DELAY;
            ST_DELAY: begin
                if (dlyCnt_q >= dlyTarget - 1'b1) begin
                    if (clkOk) begin
                        evt = EV_POR;
                        state_d = ST_RUN;
                    end else if (clock_fail_monitor_q) begin
                        evt = EV_CLKTRAP; // [RULE_02]
                        state_d = ST_RUN;
                    end else begin
                        state_d = ST_FREEZE; // [RULE_04]
                    end
                end
            end
            ST_FREEZE: begin
                if (clkOk) begin
                    evt = EV_POR;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pinLow) begin
                    state_d = ST_PIN_HOLD;
                end else if (coreEvt.trapLockup) begin
                    evt = EV_TRAP;
                end else if (coreEvt.illegalOp) begin
                    evt = EV_ILL;
                end else if (clock_fail_monitor_q && syncB_q.clockFail) begin
                    evt = EV_CLKTRAP;
                end else if (wdtTimeout) begin
                    evt = coreEvt.sleepMode ? EV_WDT_WAKE : EV_WDT_RST; // [RULE_17]
                end else if (coreEvt.swReset) begin
                    evt = EV_SW;
                end else if (coreEvt.irqWake && coreEvt.sleepMode) begin
                    evt = EV_IRQ;
                end
            end
            ST_PIN_HOLD: begin
                if (!pinLow) begin
                    evt = EV_PIN;
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_CAPTURE;
        endcase
    end

    // flag effect and target address of each event
    always_comb begin
        flgSet = '0;
        flgClr = '0;
        evtPc = rcr_pkg::VEC_RESET;
        case (evt)
            EV_POR: flgSet[rcr_pkg::FLG_POWERUP] = 1'b1; // [RULE_06]
            EV_CLKTRAP: evtPc = rcr_pkg::VEC_CLKFAIL; // [RULE_02]
            EV_PIN: begin
                flgSet[rcr_pkg::FLG_EXT] = 1'b1;
                flgClr[rcr_pkg::FLG_WDT] = 1'b1;
                case (pinMode_q)
                    rcr_pkg::MODE_SLEEP: begin
                        flgSet[rcr_pkg::FLG_DEEPSTOP] = 1'b1; // [RULE_09]
                        flgClr[rcr_pkg::FLG_DOZE] = 1'b1;
                    end
                    rcr_pkg::MODE_IDLE: begin
                        flgSet[rcr_pkg::FLG_DOZE] = 1'b1; // [RULE_10]
                        flgClr[rcr_pkg::FLG_DEEPSTOP] = 1'b1;
                    end
                    default: begin
                        flgClr[rcr_pkg::FLG_SW] = 1'b1; // [RULE_07]
                        flgClr[rcr_pkg::FLG_DOZE] = 1'b1;
                        flgClr[rcr_pkg::FLG_DEEPSTOP] = 1'b1;
                    end
                endcase
            end
            EV_SW: begin
                flgSet[rcr_pkg::FLG_SW] = 1'b1; // [RULE_08]
                flgClr[rcr_pkg::FLG_EXT] = 1'b1;
                flgClr[rcr_pkg::FLG_WDT] = 1'b1;
                flgClr[rcr_pkg::FLG_DOZE] = 1'b1;
                flgClr[rcr_pkg::FLG_DEEPSTOP] = 1'b1;
            end
            EV_WDT_RST: begin
                flgSet[rcr_pkg::FLG_WDT] = 1'b1; // [RULE_11]
                flgClr[rcr_pkg::FLG_EXT] = 1'b1;
                flgClr[rcr_pkg::FLG_SW] = 1'b1;
                flgClr[rcr_pkg::FLG_DOZE] = 1'b1;
                flgClr[rcr_pkg::FLG_DEEPSTOP] = 1'b1;
            end
            EV_WDT_WAKE: begin
                flgSet[rcr_pkg::FLG_WDT] = 1'b1; // [RULE_11]
                flgSet[rcr_pkg::FLG_DEEPSTOP] = 1'b1;
                evtPc = rcr_pkg::PC_W'(curPc + rcr_pkg::PC_STEP);
            end
            EV_IRQ: begin
                flgSet[rcr_pkg::FLG_DEEPSTOP] = 1'b1; // [RULE_12]
                evtPc = irqVector;
            end
            EV_TRAP: flgSet[rcr_pkg::FLG_TRAP] = 1'b1; // [RULE_13]
            EV_ILL: flgSet[rcr_pkg::FLG_ILL] = 1'b1; // [RULE_13]
            default: evtPc = rcr_pkg::VEC_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_CAPTURE;
        end else begin
            state_q <= state_d;
        end
    end

    // power mode seen when the pin went low
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinMode_q <= rcr_pkg::MODE_RUN;
        end else if (state_q == ST_RUN && pinLow) begin
            if (coreEvt.sleepMode) begin
                pinMode_q <= rcr_pkg::MODE_SLEEP;
            end else if (coreEvt.idleMode) begin
                pinMode_q <= rcr_pkg::MODE_IDLE;
            end else begin
                pinMode_q <= rcr_pkg::MODE_RUN;
            end
        end
    end

    // cause register: software write, then event effect on top [RULE_05] [RULE_18]
    always_comb begin
        cause_d = cause_q;
        if (wrEn && hit(addr, rcr_pkg::ADDR_CAUSE)) begin
            cause_d = wrData[rcr_pkg::FLG_W-1:0];
        end
        cause_d = (cause_d & ~flgClr) | flgSet;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cause_q <= rcr_pkg::CAUSE_RESET; // [RULE_06]
        end else begin
            cause_q <= cause_d;
        end
    end

    // oscillator control; failure switches to the fast oscillator [RULE_16]
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oscCur_q <= '0;
            oscFail_q <= 1'b0;
            oscSwReq_q <= 1'b0;
        end else if (state_q == ST_CAPTURE) begin
            oscCur_q <= oscCfgSel;
        end else if (evt == EV_CLKTRAP) begin
            oscCur_q <= rcr_pkg::OSC_SEL_FAST;
            oscFail_q <= 1'b1;
            oscSwReq_q <= 1'b0;
        end else if (wrEn && hit(addr, rcr_pkg::ADDR_OSC)) begin
            oscCur_q <= wrData[rcr_pkg::OSC_CUR_LSB +: rcr_pkg::OSC_CUR_W];
            oscFail_q <= wrData[rcr_pkg::OSC_FAIL];
            oscSwReq_q <= wrData[rcr_pkg::OSC_SWREQ];
        end
    end

    // interrupt status: sticky, cleared by a read, set wins
    always_comb begin
        intSet = '0;
        intSet[rcr_pkg::INT_CLKFAIL] = (evt == EV_CLKTRAP);
        intSet[rcr_pkg::INT_WDT] = (evt == EV_WDT_RST) || (evt == EV_WDT_WAKE);
        intSet[rcr_pkg::INT_EVENT] = (evt != EV_NONE);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intStat_q <= '0;
        end else if (rdEn && hit(addr, rcr_pkg::ADDR_ISTAT)) begin
            intStat_q <= intSet;
        end else begin
            intStat_q <= intStat_q | intSet;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            intMask_q <= '0;
        end else if (wrEn && hit(addr, rcr_pkg::ADDR_IMASK)) begin
            intMask_q <= wrData[rcr_pkg::INT_W-1:0];
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst || !rdEn) begin
            rdData <= '0;
        end else begin
            case (addr)
                rcr_pkg::ADDR_CAUSE: rdData <= rcr_pkg::DATA_W'(cause_q);
                rcr_pkg::ADDR_OSC: rdData <= rcr_pkg::DATA_W'({oscCur_q, oscFail_q,
                    2'h0, oscSwReq_q});
                rcr_pkg::ADDR_ISTAT: rdData <= rcr_pkg::DATA_W'(intStat_q);
                rcr_pkg::ADDR_IMASK: rdData <= rcr_pkg::DATA_W'(intMask_q);
                default: rdData <= '0;
            endcase
        end
    end

    // core-facing outputs, all registered [RULE_18]
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            systemReset <= 1'b1;
            coreFrozen <= 1'b0;
            pcLoad <= 1'b0;
            pcValue <= rcr_pkg::VEC_RESET;
            clockFailTrap <= 1'b0;
            irq <= 1'b0;
        end else begin
            systemReset <= (state_d != ST_RUN);
            coreFrozen <= (state_d == ST_FREEZE); // [RULE_04]
            pcLoad <= (evt != EV_NONE);
            pcValue <= (evt != EV_NONE) ? evtPc : pcValue;
            clockFailTrap <= (evt == EV_CLKTRAP);
            irq <= |(intStat_q & intMask_q);
        end
    end

    assign currentOscField = oscCur_q;

    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_trap_vector: assert property ((evt == EV_CLKTRAP) |=> pcLoad && clockFailTrap
        && pcValue == rcr_pkg::VEC_CLKFAIL && cause_q == $past(cause_q)) // [RULE_02]
        else $error("clock trap vector or flags wrong");
    a_freeze_hold: assert property ((state_q == ST_FREEZE && !clkOk) |=> coreFrozen
        && systemReset && !pcLoad) // [RULE_04]
        else $error("core not frozen without clock");
    a_pin_normal: assert property ((evt == EV_PIN && pinMode_q == rcr_pkg::MODE_RUN)
        |=> cause_q[rcr_pkg::FLG_EXT] && !cause_q[rcr_pkg::FLG_SW]
        && !cause_q[rcr_pkg::FLG_DEEPSTOP] && pcValue == rcr_pkg::VEC_RESET) // [RULE_07]
        else $error("pin reset flags wrong");
    a_sw_reset: assert property ((evt == EV_SW) |=> cause_q[rcr_pkg::FLG_SW]
        && !cause_q[rcr_pkg::FLG_EXT] && !cause_q[rcr_pkg::FLG_WDT]) // [RULE_08]
        else $error("software reset flags wrong");
    a_pin_sleep: assert property ((evt == EV_PIN && pinMode_q == rcr_pkg::MODE_SLEEP)
        |=> cause_q[rcr_pkg::FLG_DEEPSTOP] && !cause_q[rcr_pkg::FLG_DOZE]
        && cause_q[rcr_pkg::FLG_SW] == $past(cause_q[rcr_pkg::FLG_SW])) // [RULE_09]
        else $error("pin reset in sleep flags wrong");
    a_wdt_wake: assert property ((evt == EV_WDT_WAKE) |=> pcValue
        == rcr_pkg::PC_W'($past(curPc) + rcr_pkg::PC_STEP) && cause_q[rcr_pkg::FLG_WDT]
        && cause_q[rcr_pkg::FLG_DEEPSTOP]) // [RULE_11]
        else $error("watchdog wake wrong");
    a_irq_wake: assert property ((evt == EV_IRQ) |=> pcValue == $past(irqVector)
        && cause_q[rcr_pkg::FLG_DEEPSTOP] && cause_q[rcr_pkg::FLG_EXT]
        == $past(cause_q[rcr_pkg::FLG_EXT])) // [RULE_12]
        else $error("interrupt wake wrong");
    a_trap_flag: assert property ((evt == EV_TRAP) |=> cause_q[rcr_pkg::FLG_TRAP]
        && pcValue == rcr_pkg::VEC_RESET && cause_q[rcr_pkg::FLG_ILL]
        == $past(cause_q[rcr_pkg::FLG_ILL])) // [RULE_13]
        else $error("trap reset wrong");
    a_osc_fail: assert property ((evt == EV_CLKTRAP) |=> currentOscField
        == rcr_pkg::OSC_SEL_FAST && oscFail_q && !oscSwReq_q) // [RULE_16]
        else $error("clock fail switch wrong");
    a_delay_early: assert property ((state_q == ST_DELAY && dlyCnt_q < dlyTarget - 1'b1)
        |=> state_q == ST_DELAY && systemReset) // [RULE_15]
        else $error("released before delay expiry");
endmodule // rcr_top
`default_nettype wire

// *** test/rcr_core_model.sv ***
// core and clock-status model facing the recorder
`timescale 1ns/1ps
`default_nettype none
module rcr_core_model (
    // clock
    input wire logic clock,
    // toward the recorder
    output var rcr_pkg::rcr_pins_t pins,
    output var rcr_pkg::rcr_core_evt_t coreEvt
);
    logic clkReady = 1'b1;
    logic pinLow = 1'b0;
    logic [5:0] evt = 6'h00;
    logic [5:0] lvl = 6'h00;
    always_comb pins = '{~pinLow, clkReady, clkReady, clkReady, 1'b0};
    always_comb coreEvt = rcr_pkg::rcr_core_evt_t'(evt | lvl);
    // one-cycle event pulse, levels ride along
    task automatic pulse(input logic [5:0] e);
        @(posedge clock);
        evt <= e;
        @(posedge clock);
        evt <= 6'h00;
    endtask
    // master clear held low, then released
    task automatic pinReset();
        @(posedge clock);
        pinLow <= 1'b1;
        repeat (6) @(posedge clock);
        pinLow <= 1'b0;
    endtask
endmodule // rcr_core_model
`default_nettype wire

// *** test/rcr_top_test.sv ***
// self-checking bench of the reset cause recorder
`timescale 1ns/1ps
`default_nettype none
module rcr_top_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic fscmEnable = 1'b1;
    logic wdtEnable = 1'b0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic rdSeen = 1'b0;
    logic [1:0] pwrtSel = 2'h1;
    logic [2:0] oscCfgSel = 3'h4;
    logic [23:0] curPc = 24'h000100;
    logic [23:0] irqVector = 24'h000040;
    logic [23:0] vec;
    logic [3:0] addr = 4'h0;
    logic [15:0] wrData = 16'h0000;
    logic [15:0] rnd;
    logic [15:0] rdData;
    logic systemReset, coreFrozen, pcLoad, clockFailTrap, irq;
    logic [23:0] pcValue;
    logic [2:0] currentOscField;
    rcr_pkg::rcr_pins_t pins;
    rcr_pkg::rcr_core_evt_t coreEvt;
    logic [23:0] pcQ[$];
    logic [23:0] rdQ[$];
    int num_errors = 0;
    int checked = 0;
    initial forever #5 clock = ~clock;
    rcr_core_model core (.clock(clock), .pins(pins), .coreEvt(coreEvt));
    rcr_top #(.POWER_UP_DELAY_TIMER_A_CYCLES(20), .POWER_UP_DELAY_TIMER_B_CYCLES(40), .POWER_UP_DELAY_TIMER_C_CYCLES(80),
        .WDT_TIMEOUT_TICKS(4)) dut (.clock(clock), .sys_rst(sys_rst),
        .fscmEnable(fscmEnable), .pwrtSel(pwrtSel), .wdtEnable(wdtEnable),
        .oscCfgSel(oscCfgSel), .pins(pins), .coreEvt(coreEvt), .curPc(curPc),
        .irqVector(irqVector), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .systemReset(systemReset), .coreFrozen(coreFrozen),
        .pcLoad(pcLoad), .pcValue(pcValue), .clockFailTrap(clockFailTrap),
        .currentOscField(currentOscField), .irq(irq));
    task automatic compare(input string what, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic stop_test();
        num_errors += pcQ.size() + rdQ.size();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // result watcher: oldest note against each pc load and read answer
    always @(posedge clock) begin
        if (rdSeen) compare("rdData", rdQ.size() ? rdQ.pop_front() : 24'hxxxxxx, {8'h00, rdData});
        rdSeen = rdEn;
        if (pcLoad === 1'b1) compare("pcValue", pcQ.size() ? pcQ.pop_front() : 24'hxxxxxx, pcValue);
    end
    task automatic regWr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clock);
        wrEn <= 1'b0;
    endtask
    task automatic regRd(input logic [3:0] a, input logic [15:0] e);
        rdQ.push_back({8'h00, e});
        @(posedge clock);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clock);
        rdEn <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) begin
            if (pcQ.size() == 0 && rdQ.size() == 0) break;
            @(posedge clock);
        end
        repeat (3) @(posedge clock);
    endtask
    task automatic powerUp(input logic fs, input logic [1:0] sel, input logic rdy);
        @(posedge clock);
        sys_rst <= 1'b1;
        fscmEnable <= fs;
        pwrtSel <= sel;
        core.clkReady <= rdy;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
    endtask
    // event toward reset vector, then cause read back
    task automatic ev(input logic [5:0] e, input logic pin, input logic [15:0] cause);
        pcQ.push_back(rcr_pkg::VEC_RESET);
        if (pin) core.pinReset();
        else core.pulse(e);
        settle(100);
        regRd(rcr_pkg::ADDR_CAUSE, cause);
    endtask
    initial begin
        void'($urandom(34477));
        curPc <= 24'($urandom);
        oscCfgSel <= 3'($urandom);
        pcQ.push_back(rcr_pkg::VEC_RESET);
        powerUp(1'b1, 2'h1, 1'b1);
        settle(3000);
        compare("oscField", {21'h0, oscCfgSel}, {21'h0, currentOscField});
        regRd(rcr_pkg::ADDR_CAUSE, 16'h0001);
        ev(6'h20, 1'b0, 16'h0011);
        ev(6'h10, 1'b0, 16'h0091);
        ev(6'h08, 1'b0, 16'h00d1);
        vec = 24'($urandom) & 24'hfffffe;
        @(posedge clock);
        irqVector <= vec;
        core.pulse(6'h04);
        pcQ.push_back(vec);
        core.pulse(6'h06);
        settle(100);
        regRd(rcr_pkg::ADDR_CAUSE, 16'h00d3);
        ev(6'h00, 1'b1, 16'h00e1);
        core.lvl <= 6'h02;
        ev(6'h00, 1'b1, 16'h00e3);
        core.lvl <= 6'h01;
        ev(6'h00, 1'b1, 16'h00e5);
        rnd = 16'($urandom);
        regWr(rcr_pkg::ADDR_CAUSE, rnd);
        regRd(rcr_pkg::ADDR_CAUSE, {8'h00, rnd[7:0]});
        regRd(4'hf, 16'h0000);
        regRd(rcr_pkg::ADDR_ISTAT, 16'h0004);
        regWr(rcr_pkg::ADDR_IMASK, 16'h0002);
        compare("irq", 24'h0, {23'h0, irq});
        pcQ.push_back(rcr_pkg::VEC_RESET);
        wdtEnable <= 1'b1;
        settle(2000);
        core.lvl <= 6'h02;
        pcQ.push_back(curPc + rcr_pkg::PC_STEP);
        settle(2000);
        wdtEnable <= 1'b0;
        compare("irq", 24'h1, {23'h0, irq});
        regRd(rcr_pkg::ADDR_ISTAT, 16'h0006);
        regRd(rcr_pkg::ADDR_CAUSE, {8'h00, (rnd[7:0] & 8'hc1) | 8'h0a});
        settle(10);
        compare("irq", 24'h0, {23'h0, irq});
        pcQ.push_back(rcr_pkg::VEC_CLKFAIL);
        powerUp(1'b1, 2'h2, 1'b0);
        settle(3000);
        compare("oscField", {21'h0, rcr_pkg::OSC_SEL_FAST}, {21'h0, currentOscField});
        regRd(rcr_pkg::ADDR_OSC, 16'h0018);
        regRd(rcr_pkg::ADDR_CAUSE, 16'h0001);
        powerUp(1'b0, 2'h0, 1'b0);
        repeat (1200) @(posedge clock);
        compare("coreFrozen", 24'h1, {23'h0, coreFrozen});
        pcQ.push_back(rcr_pkg::VEC_RESET);
        core.clkReady <= 1'b1;
        settle(100);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        stop_test();
    end
endmodule // rcr_top_test
`default_nettype wire
